// File: csc_regs.vh
// Build options, constants and register map of the colour-space converter
`ifndef CSC_REGS_VH
`define CSC_REGS_VH

// Frame size in pixels and lines
`define CSC_FRAME_W 640
`define CSC_FRAME_H 480

// 1: three planes side by side on one beat, 0: three planes in sequence
`define CSC_PAR 0

// Sample formats
`define CSC_IN_BITS 8
`define CSC_OUT_BITS 8
`define CSC_IN_SIGNED 0
`define CSC_OUT_SIGNED 0

// Output guard band
`define CSC_OUT_GUARD 0
`define CSC_OUT_MIN 0
`define CSC_OUT_MAX 255

// Result scale is 2 to the power of this shift, 0 to 6
`define CSC_SCALE_SH 0

// Fraction removal: 1 rounds to nearest, 0 truncates
`define CSC_ROUND 1

// Signed to unsigned conversion
`define CSC_S2U_ZERO 0
`define CSC_S2U_ABS 1
`define CSC_S2U_IGNORE 2
`define CSC_S2U_MODE 0

// 1 saturates to the range, 0 wraps
`define CSC_SATURATE 1

// Fixed-point formats of coefficients and summands
`define CSC_COEF_SIGNED 1
`define CSC_COEF_INT 8
`define CSC_SUM_SIGNED 1
`define CSC_SUM_INT 8
`define CSC_FRAC 8
`define CSC_COEF_W (`CSC_COEF_SIGNED + `CSC_COEF_INT + `CSC_FRAC)
`define CSC_SUM_W (`CSC_SUM_SIGNED + `CSC_SUM_INT + `CSC_FRAC)
`define CSC_ACC_W (`CSC_IN_BITS + `CSC_COEF_W + `CSC_SUM_W)
`define CSC_DIN_W ((`CSC_PAR != 0) ? 3 * `CSC_IN_BITS : `CSC_IN_BITS)
`define CSC_DOUT_W ((`CSC_PAR != 0) ? 3 * `CSC_OUT_BITS : `CSC_OUT_BITS)

// Coefficients K<out><in> and summands S<out>: R, B, G in; Y, Cb, Cr out
`define CSC_K00 77
`define CSC_K01 29
`define CSC_K02 150
`define CSC_S0 0
`define CSC_K10 (-43)
`define CSC_K11 128
`define CSC_K12 (-85)
`define CSC_S1 32768
`define CSC_K20 128
`define CSC_K21 (-21)
`define CSC_K22 (-107)
`define CSC_S2 32768

// Register map, byte addresses
`define CSC_REG_CTRL 4'h0
`define CSC_REG_STAT 4'h4
`define CSC_REG_FRAMES 4'h8
`define CSC_REG_SIZE 4'hc
`define CSC_CTRL_GO 0
`define CSC_CTRL_RST 1'h1

`endif

// File: csc_fit.v
// Per-plane scaling, fraction removal, sign conversion and range fitting
`timescale 1ns/100ps
`include "csc_regs.vh"

module csc_fit (
  // Weighted sum with fraction bits
  input  wire [`CSC_ACC_W-1:0]   acc,
  // Fitted output sample
  output reg  [`CSC_OUT_BITS-1:0] res
);
  localparam AW = `CSC_ACC_W;
  localparam OW = `CSC_OUT_BITS;
  localparam XW = AW + 8;
  localparam CF = `CSC_FRAC;
  localparam OS = `CSC_OUT_SIGNED;
  localparam signed [XW-1:0] ONE  = 1;
  localparam signed [XW-1:0] HALF = ONE <<< (CF - 1);
  localparam signed [XW-1:0] LO   = (`CSC_OUT_GUARD != 0) ? `CSC_OUT_MIN :
                                    (OS != 0) ? -(2 ** (OW - 1)) : 0;
  localparam signed [XW-1:0] HI   = (`CSC_OUT_GUARD != 0) ? `CSC_OUT_MAX :
                                    (OS != 0) ? (2 ** (OW - 1)) - 1 : (2 ** OW) - 1;

  wire signed [XW-1:0] wide   = {{(XW - AW){acc[AW-1]}}, acc};
  wire signed [XW-1:0] scaled = wide <<< `CSC_SCALE_SH;
  wire signed [XW-1:0] rnd    = scaled + ((`CSC_ROUND != 0) ? HALF : 0);
  wire signed [XW-1:0] ip     = rnd >>> CF;
  reg  signed [XW-1:0] uv;

  always @*
  begin
    uv = ip;
    if (OS == 0 && ip < 0)
    begin
      case (`CSC_S2U_MODE)
        `CSC_S2U_ZERO: uv = 0;
        `CSC_S2U_ABS:  uv = -ip;
        default:       uv = ip;
      endcase
    end
  end

  always @*
  begin
    res = uv[OW-1:0];
    if (`CSC_SATURATE != 0)
    begin
      if (uv < LO)
        res = LO[OW-1:0];
      else if (uv > HI)
        res = HI[OW-1:0];
    end
  end
endmodule // csc_fit

// File: csc_gather.v
// Input plane gatherer with a two-pixel skid so registered ready keeps full rate
`timescale 1ns/100ps
`include "csc_regs.vh"

module csc_gather (
  // Clock, reset and enable
  input  wire                  mclk,
  input  wire                  rst,
  input  wire                  ce,
  // Frame hold from the converter, next-cycle value
  input  wire                  hold_d,
  // Input stream
  input  wire [`CSC_DIN_W-1:0] din_data,
  input  wire                  din_valid,
  input  wire                  din_startofpacket,
  input  wire                  din_endofpacket,
  output wire                  din_ready,
  // Whole pixels towards the pipeline
  input  wire                  take,
  output wire [3*`CSC_IN_BITS-1:0] pix_data,
  output wire                  pix_sop,
  output wire                  pix_eop,
  output wire                  pix_valid
);
  localparam PAR = `CSC_PAR;
  localparam IW  = `CSC_IN_BITS;
  localparam PW  = 3 * IW + 2;

  reg  [PW-1:0]   slot0_q;
  reg  [PW-1:0]   slot1_q;
  reg  [1:0]      cnt_q;
  reg  [1:0]      cnt_d;
  reg             rdy_q;
  wire [3*IW-1:0] pix_in;
  wire            sop_in;
  wire            accept = ce & din_valid & rdy_q;
  wire            push;
  wire            pop    = ce & take & (cnt_q != 2'd0);
  wire [PW-1:0]   word   = {din_endofpacket, sop_in, pix_in};

  generate
    if (PAR != 0)
    begin : g_par
      assign pix_in = din_data;
      assign sop_in = din_startofpacket;
      assign push   = accept;
    end
    else
    begin : g_seq
      reg [1:0]      pc_q;
      reg [2*IW-1:0] part_q;
      reg            sop_q;
      assign pix_in = {din_data, part_q};
      assign sop_in = sop_q;
      assign push   = accept & (pc_q == 2'd2);
      always @(posedge mclk)
      begin
        if (rst)
        begin
          pc_q   <= 2'd0;
          part_q <= {(2 * IW){1'b0}};
          sop_q  <= 1'b0;
        end
        else if (accept)
        begin
          pc_q   <= (pc_q == 2'd2) ? 2'd0 : pc_q + 2'd1;
          part_q <= {din_data, part_q[2*IW-1:IW]};
          if (pc_q == 2'd0)
            sop_q <= din_startofpacket;
        end
      end
    end
  endgenerate

  always @*
  begin
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_q   <= 2'd0;
      rdy_q   <= 1'b0;
      slot0_q <= {PW{1'b0}};
      slot1_q <= {PW{1'b0}};
    end
    else if (ce)
    begin
      cnt_q <= cnt_d;
      rdy_q <= (cnt_d != 2'd2) & ~hold_d;
      if (pop)
        slot0_q <= (push && cnt_q == 2'd1) ? word : slot1_q;
      else if (push && cnt_q == 2'd0)
        slot0_q <= word;
      if (push && !(pop && cnt_q == 2'd1) && cnt_q != 2'd0)
        slot1_q <= word;
    end
  end

  assign din_ready = rdy_q;
  assign pix_valid = cnt_q != 2'd0;
  assign pix_data  = slot0_q[3*IW-1:0];
  assign pix_sop   = slot0_q[3*IW];
  assign pix_eop   = slot0_q[3*IW+1];
endmodule // csc_gather

// File: csc_color_convert.v
// Colour-space matrix converter: stream in, three weighted sums, fitted stream out
`timescale 1ns/100ps
`include "csc_regs.vh"

module csc_color_convert (
  // Clock, reset and enable
  input  wire                   mclk,
  input  wire                   rst,
  input  wire                   ce,
  // Register bus
  input  wire [3:0]             avs_address,
  input  wire                   avs_read,
  input  wire                   avs_write,
  input  wire [31:0]            avs_writedata,
  input  wire [3:0]             avs_byteenable,
  output wire [31:0]            avs_readdata,
  output wire                   avs_waitrequest,
  // Input stream
  input  wire [`CSC_DIN_W-1:0]  din_data,
  input  wire                   din_valid,
  input  wire                   din_startofpacket,
  input  wire                   din_endofpacket,
  output wire                   din_ready,
  // Output stream
  output wire [`CSC_DOUT_W-1:0] dout_data,
  output wire                   dout_valid,
  output wire                   dout_startofpacket,
  output wire                   dout_endofpacket,
  input  wire                   dout_ready
);
  localparam PAR  = `CSC_PAR;
  localparam IW   = `CSC_IN_BITS;
  localparam OW   = `CSC_OUT_BITS;
  localparam AW   = `CSC_ACC_W;
  localparam DW   = `CSC_DOUT_W;
  localparam IN_S = `CSC_IN_SIGNED;

  integer i;
  genvar  k;

  // Fixed constants, cut to their stored format and widened
  function integer kval;
    input integer n;
    begin
      case (n)
        0:       kval = `CSC_K00;
        1:       kval = `CSC_K01;
        2:       kval = `CSC_K02;
        3:       kval = `CSC_S0;
        4:       kval = `CSC_K10;
        5:       kval = `CSC_K11;
        6:       kval = `CSC_K12;
        7:       kval = `CSC_S1;
        8:       kval = `CSC_K20;
        9:       kval = `CSC_K21;
        10:      kval = `CSC_K22;
        11:      kval = `CSC_S2;
        default: kval = 0;
      endcase
    end
  endfunction

  function [AW-1:0] fixk;
    input integer v;
    input integer w;
    input integer sgn;
    integer j;
    begin
      fixk = v;
      for (j = w; j < AW; j = j + 1)
        fixk[j] = (sgn != 0) & fixk[w-1];
    end
  endfunction

  // Gatherer outputs
  wire [3*IW-1:0] pix_data;
  wire            pix_sop;
  wire            pix_eop;
  wire            pix_valid;

  // Pipeline
  wire signed [AW-1:0] xin   [0:2];
  wire signed [AW-1:0] acc_d [0:2];
  wire        [OW-1:0] fit_w [0:2];
  reg         [AW-1:0] acc_q [0:2];
  reg         [OW-1:0] f_q   [0:2];
  reg                  a_v_q;
  reg                  a_sop_q;
  reg                  a_eop_q;
  reg                  b_v_q;
  reg                  b_sop_q;
  reg                  b_eop_q;

  // Output stage
  reg  [DW-1:0] data_q;
  reg           dv_q;
  reg           sop_q;
  reg           eop_q;
  reg  [1:0]    beat_q;
  reg  [OW-1:0] sh1_q;
  reg  [OW-1:0] sh2_q;
  reg           last_q;
  wire [DW-1:0] first_w;
  wire [DW-1:0] next_w;
  wire          adv_ok;
  wire          advance = ce & adv_ok;
  wire          out_fire = ce & dv_q & dout_ready;

  // Frame tracking and bus
  reg        pend_q;
  reg        mid_q;
  reg        go_q;
  reg        wait_q;
  reg [31:0] rdata_q;
  reg [31:0] frames_q;
  reg [31:0] rd_mux;
  wire in_acc  = ce & din_valid & din_ready;
  wire in_eop  = in_acc & din_endofpacket;
  wire out_eop = out_fire & eop_q;
  wire wr_go   = ce & avs_write & ~wait_q & (avs_address == `CSC_REG_CTRL) & avs_byteenable[0];
  wire go_d    = wr_go ? avs_writedata[`CSC_CTRL_GO] : go_q;
  wire pend_d  = in_eop | (pend_q & ~out_eop);
  wire mid_d   = in_eop ? 1'b0 : (in_acc ? 1'b1 : mid_q);
  wire hold_d  = pend_d | (~go_d & ~mid_d);

  csc_gather u_gather (
    .mclk              (mclk),
    .rst               (rst),
    .ce                (ce),
    .hold_d            (hold_d),
    .din_data          (din_data),
    .din_valid         (din_valid),
    .din_startofpacket (din_startofpacket),
    .din_endofpacket   (din_endofpacket),
    .din_ready         (din_ready),
    .take              (advance),
    .pix_data          (pix_data),
    .pix_sop           (pix_sop),
    .pix_eop           (pix_eop),
    .pix_valid         (pix_valid)
  );

  generate
    for (k = 0; k < 3; k = k + 1)
    begin : g_plane
      wire [IW-1:0] x = pix_data[k*IW +: IW];
      assign xin[k] = {{(AW - IW){(IN_S != 0) & x[IW-1]}}, x};
      // Plane order follows the constant order; coefficient and summand share fraction bits
      assign acc_d[k] = $signed(fixk(kval(4 * k), `CSC_COEF_W, `CSC_COEF_SIGNED)) * xin[0]
                      + $signed(fixk(kval(4 * k + 1), `CSC_COEF_W, `CSC_COEF_SIGNED)) * xin[1]
                      + $signed(fixk(kval(4 * k + 2), `CSC_COEF_W, `CSC_COEF_SIGNED)) * xin[2]
                      + $signed(fixk(kval(4 * k + 3), `CSC_SUM_W, `CSC_SUM_SIGNED));
      csc_fit u_fit (
        .acc (acc_q[k]),
        .res (fit_w[k])
      );
    end
  endgenerate

  generate
    if (PAR != 0)
    begin : g_opar
      assign first_w = {f_q[2], f_q[1], f_q[0]};
      assign next_w  = first_w;
      assign adv_ok  = ~dv_q | dout_ready;
    end
    else
    begin : g_oseq
      assign first_w = f_q[0];
      assign next_w  = (beat_q == 2'd0) ? sh1_q : sh2_q;
      assign adv_ok  = ~dv_q | (dout_ready & (beat_q == 2'd2));
    end
  endgenerate

  // Pipeline control: the whole pipe moves together, bubbles pass as invalid
  always @(posedge mclk)
  begin
    if (rst)
    begin
      a_v_q   <= 1'b0;
      a_sop_q <= 1'b0;
      a_eop_q <= 1'b0;
      b_v_q   <= 1'b0;
      b_sop_q <= 1'b0;
      b_eop_q <= 1'b0;
    end
    else if (advance)
    begin
      a_v_q   <= pix_valid;
      a_sop_q <= pix_sop;
      a_eop_q <= pix_eop;
      b_v_q   <= a_v_q;
      b_sop_q <= a_sop_q;
      b_eop_q <= a_eop_q;
    end
  end

  always @(posedge mclk)
  begin
    if (advance)
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        acc_q[i] <= acc_d[i];
        f_q[i]   <= fit_w[i];
      end
    end
  end

  always @(posedge mclk)
  begin
    if (rst)
    begin
      data_q <= {DW{1'b0}};
      dv_q   <= 1'b0;
      sop_q  <= 1'b0;
      eop_q  <= 1'b0;
      beat_q <= 2'd0;
      sh1_q  <= {OW{1'b0}};
      sh2_q  <= {OW{1'b0}};
      last_q <= 1'b0;
    end
    else if (advance)
    begin
      dv_q   <= b_v_q;
      data_q <= first_w;
      sop_q  <= b_v_q & b_sop_q;
      eop_q  <= b_v_q & b_eop_q & (PAR != 0);
      beat_q <= 2'd0;
      sh1_q  <= f_q[1];
      sh2_q  <= f_q[2];
      last_q <= b_eop_q;
    end
    else if (out_fire && PAR == 0)
    begin
      beat_q <= beat_q + 2'd1;
      data_q <= next_w;
      sop_q  <= 1'b0;
      eop_q  <= (beat_q == 2'd1) & last_q;
    end
  end

  // Frame hold: the next frame waits until the last sample has left
  always @(posedge mclk)
  begin
    if (rst)
    begin
      pend_q   <= 1'b0;
      mid_q    <= 1'b0;
      go_q     <= `CSC_CTRL_RST;
      frames_q <= 32'h00000000;
    end
    else
    begin
      pend_q <= pend_d;
      mid_q  <= mid_d;
      go_q   <= go_d;
      if (out_eop)
        frames_q <= frames_q + 32'h00000001;
    end
  end

  always @*
  begin
    case (avs_address)
      `CSC_REG_CTRL:   rd_mux = {31'h00000000, go_q};
      `CSC_REG_STAT:   rd_mux = {29'h00000000, dv_q, mid_q, pend_q};
      `CSC_REG_FRAMES: rd_mux = frames_q;
      `CSC_REG_SIZE:   rd_mux = {16'd`CSC_FRAME_H, 16'd`CSC_FRAME_W};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // Bus slave: one wait cycle, then a single cycle with waitrequest low
  always @(posedge mclk)
  begin
    if (rst)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else if (ce)
    begin
      if ((avs_read | avs_write) & wait_q)
      begin
        wait_q  <= 1'b0;
        rdata_q <= rd_mux;
      end
      else
      begin
        wait_q <= 1'b1;
      end
    end
  end

  assign avs_readdata       = rdata_q;
  assign avs_waitrequest    = wait_q;
  assign dout_data          = data_q;
  assign dout_valid         = dv_q;
  assign dout_startofpacket = sop_q;
  assign dout_endofpacket   = eop_q;
endmodule // csc_color_convert

// File: csc_color_convert_props.sv
// Port checker for the colour-space converter
`timescale 1ns/100ps
`include "csc_regs.vh"

module csc_color_convert_props (
  // Clock and control
  input wire                   mclk,
  input wire                   rst,
  input wire                   ce,
  // Bus handshake
  input wire                   avs_read,
  input wire                   avs_write,
  input wire                   avs_waitrequest,
  // Streams
  input wire                   din_valid,
  input wire                   din_endofpacket,
  input wire                   din_ready,
  input wire [`CSC_DOUT_W-1:0] dout_data,
  input wire                   dout_valid,
  input wire                   dout_startofpacket,
  input wire                   dout_endofpacket,
  input wire                   dout_ready
);
  wire        din_tk  = din_valid & din_ready & ce;
  wire        dout_tk = dout_valid & dout_ready & ce;
  reg  [1:0]  ipl_q;
  reg  [1:0]  opl_q;
  reg  [15:0] fly_q;
  reg         pend_q;

  // Plane position on each side, beats in flight, frame awaiting drain
  always @(posedge mclk)
  begin
    if (rst)
    begin
      ipl_q  <= 2'h0;
      opl_q  <= 2'h0;
      fly_q  <= 16'h0;
      pend_q <= 1'b0;
    end
    else
    begin
      ipl_q  <= din_tk ? ((ipl_q == 2'h2) ? 2'h0 : ipl_q + 2'h1) : ipl_q;
      opl_q  <= dout_tk ? ((opl_q == 2'h2) ? 2'h0 : opl_q + 2'h1) : opl_q;
      fly_q  <= fly_q + {15'h0, din_tk} - {15'h0, dout_tk};
      pend_q <= (din_tk & din_endofpacket) ? 1'b1 : ((dout_tk & dout_endofpacket) ? 1'b0 : pend_q);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_reset_idle: assert property (disable iff (1'b0) rst |=> !dout_valid && !din_ready && avs_waitrequest)
    else $error("outputs not idle after reset");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  a_wait_once: assert property (!avs_waitrequest && ce |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_dout_hold: assert property (dout_valid && !dout_ready |=> dout_valid && $stable(dout_data))
    else $error("output beat changed before taken");
  a_eop_block: assert property (pend_q |-> !din_ready)
    else $error("input ready before previous frame drained");
  a_no_phantom: assert property (dout_valid |-> fly_q != 16'h0)
    else $error("output beat without input");
  a_sop_plane: assert property (dout_valid && dout_startofpacket |-> opl_q == 2'h0)
    else $error("start of frame not on first plane");
  a_eop_plane: assert property (dout_valid && dout_endofpacket |-> opl_q == 2'h2)
    else $error("end of frame not on last plane");
  a_short_pipe: assert property ((din_tk && ipl_q == 2'h2 && fly_q == 16'h2) ##1 ce [*3] |=> dout_valid)
    else $error("pixel latency too long");

  c_frame_out: cover property (dout_tk && dout_endofpacket);
  c_in_stall: cover property (din_valid && !din_ready);
  c_bus_done: cover property ((avs_read || avs_write) && !avs_waitrequest);
endmodule // csc_color_convert_props

bind csc_color_convert csc_color_convert_props csc_color_convert_props_i (
  .mclk(mclk), .rst(rst), .ce(ce), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .din_valid(din_valid), .din_endofpacket(din_endofpacket),
  .din_ready(din_ready), .dout_data(dout_data), .dout_valid(dout_valid),
  .dout_startofpacket(dout_startofpacket), .dout_endofpacket(dout_endofpacket), .dout_ready(dout_ready)
);

// File: csc_stream_peer.sv
// Upstream source and downstream sink around the converter
`timescale 1ns/100ps
`include "csc_regs.vh"

module csc_stream_peer (
  // Clock, reset, pacing
  input  wire                  mclk,
  input  wire                  rst,
  input  wire                  ce,
  input  wire                  gap,
  input  wire                  stall,
  // Source side
  output reg  [`CSC_DIN_W-1:0] din_data = '0,
  output reg                   din_valid = 1'b0,
  output reg                   din_startofpacket = 1'b0,
  output reg                   din_endofpacket = 1'b0,
  input  wire                  din_ready,
  // Sink side
  input  wire [`CSC_DOUT_W-1:0] dout_data,
  input  wire                  dout_valid,
  input  wire                  dout_startofpacket,
  input  wire                  dout_endofpacket,
  output reg                   dout_ready = 1'b0
);
  logic [`CSC_DIN_W+1:0]  in_q[$];
  logic [`CSC_DOUT_W+1:0] out_q[$];

  always @(posedge mclk)
  begin
    if (rst)
    begin
      din_valid  <= 1'b0;
      dout_ready <= 1'b0;
    end
    else
    begin
      // A beat is held until taken; released data toggles
      if (!din_valid || (din_ready && ce))
      begin
        if (in_q.size() != 0 && !gap)
        begin
          {din_startofpacket, din_endofpacket, din_data} <= in_q.pop_front();
          din_valid <= 1'b1;
        end
        else
        begin
          din_valid         <= 1'b0;
          din_startofpacket <= 1'b0;
          din_endofpacket   <= 1'b0;
          din_data          <= ~din_data;
        end
      end
      dout_ready <= !stall;
      if (dout_valid && dout_ready && ce)
        out_q.push_back({dout_startofpacket, dout_endofpacket, dout_data});
    end
  end
endmodule // csc_stream_peer

// File: tb_top.sv
// Self-checking bench for the colour-space converter
`timescale 1ns/100ps
`include "csc_regs.vh"

module tb_top;
  reg                     mclk = 1'b0;
  reg                     rst = 1'b1;
  reg                     ce = 1'b1;
  reg  [3:0]              avs_address = 4'h0;
  reg                     avs_read = 1'b0;
  reg                     avs_write = 1'b0;
  reg  [31:0]             avs_writedata = 32'h0;
  reg  [3:0]              avs_byteenable = 4'hf;
  wire [31:0]             avs_readdata;
  wire                    avs_waitrequest;
  wire [`CSC_DIN_W-1:0]   din_data;
  wire                    din_valid;
  wire                    din_sop;
  wire                    din_eop;
  wire                    din_ready;
  wire [`CSC_DOUT_W-1:0]  dout_data;
  wire                    dout_valid;
  wire                    dout_sop;
  wire                    dout_eop;
  wire                    dout_ready;
  reg                     gap = 1'b0;
  reg                     stall = 1'b0;
  reg                     stall_en = 1'b0;
  reg  [15:0]             rnd_q = 16'h1064;
  reg  [15:0]             rnd_px = 16'h1064;
  reg  [31:0]             rd;
  reg  [9:0]              exp_q[$];
  integer                 n_mismatch = 0;
  integer                 cmp_count = 0;
  integer                 cyc = 0;
  localparam [23:0]       corners [0:3] = '{24'h000000, 24'hffffff, 24'h00ff00, 24'h0000ff};

  always #10 mclk = ~mclk;

  csc_color_convert csc_color_convert_i (
    .mclk(mclk), .rst(rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .din_data(din_data),
    .din_valid(din_valid), .din_startofpacket(din_sop), .din_endofpacket(din_eop),
    .din_ready(din_ready), .dout_data(dout_data), .dout_valid(dout_valid),
    .dout_startofpacket(dout_sop), .dout_endofpacket(dout_eop), .dout_ready(dout_ready)
  );

  csc_stream_peer csc_stream_peer_i (
    .mclk(mclk), .rst(rst), .ce(ce), .gap(gap), .stall(stall), .din_data(din_data),
    .din_valid(din_valid), .din_startofpacket(din_sop), .din_endofpacket(din_eop),
    .din_ready(din_ready), .dout_data(dout_data), .dout_valid(dout_valid),
    .dout_startofpacket(dout_sop), .dout_endofpacket(dout_eop), .dout_ready(dout_ready)
  );

  function automatic [15:0] lfsr(input [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected fitted sample of output plane o for pixel {p2,p1,p0}
  function automatic [7:0] exp_pl(input integer o, input [23:0] px);
    integer a;
    case (o)
      0: a = `CSC_K00 * int'(px[7:0]) + `CSC_K01 * int'(px[15:8]) + `CSC_K02 * int'(px[23:16]) + `CSC_S0;
      1: a = `CSC_K10 * int'(px[7:0]) + `CSC_K11 * int'(px[15:8]) + `CSC_K12 * int'(px[23:16]) + `CSC_S1;
      default: a = `CSC_K20 * int'(px[7:0]) + `CSC_K21 * int'(px[15:8]) + `CSC_K22 * int'(px[23:16]) + `CSC_S2;
    endcase
    a = a * (1 << `CSC_SCALE_SH);
    a = (a + (`CSC_ROUND ? (1 << (`CSC_FRAC - 1)) : 0)) >>> `CSC_FRAC;
    if (a < 0) a = 0;
    if (a > `CSC_OUT_MAX) a = `CSC_OUT_MAX;
    return a[7:0];
  endfunction

  task automatic cmp_beat(input string what, input [9:0] e, input [9:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask

  task automatic cmp_word(input string what, input [31:0] e, input [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask

  // Bus cycle held until waitrequest is sampled low
  task automatic bus(input bit wr, input [3:0] a, input [31:0] wd, output [31:0] r);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0 && cyc < 20000);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic frame(input integer np, input bit corner);
    reg [23:0] px;
    integer    i, j;
    for (i = 0; i < np; i++)
    begin
      rnd_px = lfsr(rnd_px);
      px[15:0] = rnd_px;
      rnd_px = lfsr(rnd_px);
      px[23:16] = rnd_px[7:0];
      if (corner) px = corners[i];
      for (j = 0; j < 3; j++)
      begin
        csc_stream_peer_i.in_q.push_back({i == 0 && j == 0, i == np - 1 && j == 2, px[8*j +: 8]});
        exp_q.push_back({i == 0 && j == 0, i == np - 1 && j == 2, exp_pl(j, px)});
      end
    end
  endtask

  task automatic check_out(input string what);
    integer t;
    t = 0;
    while (csc_stream_peer_i.out_q.size() < exp_q.size() && t < 5000)
    begin
      @(posedge mclk);
      t++;
    end
    while (exp_q.size() != 0)
      cmp_beat(what, exp_q.pop_front(), csc_stream_peer_i.out_q.size() ? csc_stream_peer_i.out_q.pop_front() : 'x);
    cmp_word("extra beats", 32'h0, csc_stream_peer_i.out_q.size());
  endtask

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Random pacing of source, sink and clock enable
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    rnd_q <= lfsr(rnd_q);
    gap <= stall_en & rnd_q[0];
    stall <= stall_en & rnd_q[3];
    ce <= !(stall_en && rnd_q[7:5] == 3'h0);
    if (cyc == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    bus(1'b0, `CSC_REG_CTRL, 32'h0, rd);
    cmp_word("ctrl reset", 32'h1, rd);
    bus(1'b1, 4'h2, 32'hffffffff, rd);
    bus(1'b0, 4'h2, 32'h0, rd);
    cmp_word("unmapped read", 32'h0, rd);
    bus(1'b0, `CSC_REG_SIZE, 32'h0, rd);
    cmp_word("frame size", (`CSC_FRAME_H << 16) | `CSC_FRAME_W, rd);
    $display("test registers done");
    frame(4, 1'b1);
    check_out("corner beat");
    $display("test corner pixels done");
    stall_en <= 1'b1;
    repeat (3) frame(8, 1'b0);
    check_out("random beat");
    stall_en <= 1'b0;
    @(posedge mclk);
    bus(1'b1, `CSC_REG_CTRL, 32'h0, rd);
    frame(2, 1'b0);
    repeat (30) @(posedge mclk);
    cmp_word("held beats", 32'h0, csc_stream_peer_i.out_q.size());
    bus(1'b1, `CSC_REG_CTRL, 32'h1, rd);
    check_out("resumed beat");
    bus(1'b0, `CSC_REG_FRAMES, 32'h0, rd);
    cmp_word("frames out", 32'h5, rd);
    $display("test random frames done");
    conclude();
  end
endmodule // tb_top
